// >>> cpm_conv_model.sv
`timescale 1ns/1ns
module cpm_conv_model (
  // request side
  input wire logic aclk,
  input wire logic conv_req_r,
  input wire logic mux_sel_r,
  // codes and faults chosen by the bench
  input wire logic [15:0] shunt_a,
  input wire logic [15:0] shunt_b,
  input wire logic [15:0] rail,
  input wire logic short_frame,
  // serial link
  output logic link_clk,
  output logic link_data,
  output logic link_frame_n,
  output logic [15:0] n_frames
);
  logic [15:0] word;
  logic pick_b;
  initial
  begin
    link_clk = 1'b0;
    link_data = 1'b0;
    link_frame_n = 1'b1;
    n_frames = 16'h0000;
    pick_b = 1'b0;
  end
  // clock stands low between frames; data shows the inverse of its last bit
  task automatic send(input logic [15:0] w, input int nb);
    link_frame_n = 1'b0;
    for (int i = 15; i > 15 - nb; i--)
    begin
      link_data = w[i];
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
    end
    #62 link_frame_n = 1'b1;
    link_data = ~link_data;
    // keep the gap short: the next request follows about four aclk after frame end
    #16;
  endtask
  always @(posedge aclk)
  begin
    if (conv_req_r === 1'b1)
    begin
      if (mux_sel_r === cpm_pkg::MUX_RAIL)
        word = rail;
      else
      begin
        word = pick_b ? shunt_b : shunt_a;
        pick_b = !pick_b;
      end
      if (short_frame)
        send(word, 15);
      send(word, 16);
      n_frames = n_frames + 16'h0001;
    end
  end
endmodule

// >>> cpm_core.sv
// Contract
// RQ1 - converter results arrive as 16-bit codes from a delta-sigma core.
// RQ2 - one shunt code count equals 2.5 microvolts.
// RQ3 - shunt codes are limited to the span of about 80 millivolts.
// RQ4 - a writable calibration register holds the fitted sense resistor value.
// RQ5 - each completed conversion yields a current value stored in its own register.
// RQ6 - the input selector alternates between shunt and rail measurements.
// RQ7 - power is computed from rail voltage and current and stored for readout.
// RQ8 - shunt, current, rail and power results are readable by the processor.
// RQ9 - every new result is compared against a programmable limit.
// RQ10 - the limit applies to overcurrent, overvoltage or overpower by selection.
// RQ11 - a programmable averaging count combines conversions before reporting.
// RQ12 - current is shunt times calibration scaled; power is current times rail scaled.
// RQ13 - an out-of-range result sets a sticky alert flag until read.
`timescale 1ns/1ns
module cpm_core #(
  parameter int CODE_W = 16,
  parameter int AVG_LOG_MAX = 7
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter link
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_frame_n,
  output logic conv_req_r,
  output logic mux_sel_r,
  // interrupt
  output logic irq_r
);

  if (CODE_W != cpm_pkg::CODE_W || AVG_LOG_MAX < 0 || AVG_LOG_MAX > cpm_pkg::AVG_LOG_MAX)
  begin : g_check
    $error("cpm_core: unsupported code width or averaging depth");
  end

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SHUNT = 5'b00010,
    S_RAIL = 5'b00100,
    S_CUR = 5'b01000,
    S_PWR = 5'b10000
  } cpm_state_t;

  function automatic logic [15:0] cpm_merge(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    cpm_merge = old;
    if (strb[0])
    begin
      cpm_merge[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      cpm_merge[15:8] = data[15:8];
    end
  endfunction

  logic [CODE_W-1:0] rx_word;
  logic rx_valid;

  // RQ1 serial code capture
  cpm_rx #(.CODE_W(CODE_W)) u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .link_clk(link_clk),
    .link_data(link_data),
    .link_frame_n(link_frame_n),
    .word_r(rx_word),
    .valid_r(rx_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file and axi slave

  logic [5:0] cfg_r, cfg_nxt;
  logic [15:0] cal_r, cal_nxt;
  logic [15:0] limit_r, limit_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] stat_set;
  logic irq_nxt;
  cpm_pkg::cpm_result_t res_r, res_nxt;

  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_nxt, wready_nxt, bvalid_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic arready_nxt, rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic aw_h, w_h, do_wr, rd_take;

  always_comb
  begin
    cfg_nxt = cfg_r;
    cal_nxt = cal_r;
    limit_nxt = limit_r;
    mask_nxt = mask_r;
    bresp_nxt = s_axi_bresp;
    rresp_nxt = s_axi_rresp;
    rdata_nxt = s_axi_rdata;
    aw_h = aw_have_r | (s_axi_awvalid & s_axi_awready);
    w_h = w_have_r | (s_axi_wvalid & s_axi_wready);
    aw_addr_nxt = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : aw_addr_r;
    w_data_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data_r;
    w_strb_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : w_strb_r;
    // address and data may come in either order; answer only once both are held
    do_wr = aw_h & w_h & ~s_axi_bvalid;
    aw_have_nxt = aw_h & ~do_wr;
    w_have_nxt = w_h & ~do_wr;
    bvalid_nxt = do_wr | (s_axi_bvalid & ~s_axi_bready);
    awready_nxt = ~aw_have_nxt;
    wready_nxt = ~w_have_nxt;
    if (do_wr)
    begin
      bresp_nxt = cpm_pkg::RESP_OKAY;
      unique case (aw_addr_nxt)
        cpm_pkg::OFS_CONFIG:
        begin
          cfg_nxt = 6'(cpm_merge({10'h000, cfg_r}, w_data_nxt, w_strb_nxt));
        end
        // RQ4 calibration write
        cpm_pkg::OFS_CAL: cal_nxt = cpm_merge(cal_r, w_data_nxt, w_strb_nxt);
        cpm_pkg::OFS_LIMIT: limit_nxt = cpm_merge(limit_r, w_data_nxt, w_strb_nxt);
        cpm_pkg::OFS_MASK:
        begin
          if (w_strb_nxt[0])
          begin
            mask_nxt = w_data_nxt[1:0];
          end
        end
        cpm_pkg::OFS_SHUNT, cpm_pkg::OFS_RAIL, cpm_pkg::OFS_POWER, cpm_pkg::OFS_CURRENT,
        cpm_pkg::OFS_STATUS: bresp_nxt = cpm_pkg::RESP_OKAY;
        default: bresp_nxt = cpm_pkg::RESP_SLVERR;
      endcase
    end
    rd_take = s_axi_arvalid & s_axi_arready;
    rvalid_nxt = rd_take | (s_axi_rvalid & ~s_axi_rready);
    arready_nxt = ~rvalid_nxt;
    if (rd_take)
    begin
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = cpm_pkg::RESP_OKAY;
      // RQ8 result readout
      unique case (s_axi_araddr)
        cpm_pkg::OFS_CONFIG: rdata_nxt = {26'h0, cfg_r};
        cpm_pkg::OFS_SHUNT: rdata_nxt = {16'h0000, res_r.shunt};
        cpm_pkg::OFS_RAIL: rdata_nxt = {16'h0000, res_r.rail};
        cpm_pkg::OFS_POWER: rdata_nxt = {16'h0000, res_r.power};
        cpm_pkg::OFS_CURRENT: rdata_nxt = {16'h0000, res_r.current};
        cpm_pkg::OFS_CAL: rdata_nxt = {16'h0000, cal_r};
        cpm_pkg::OFS_LIMIT: rdata_nxt = {16'h0000, limit_r};
        cpm_pkg::OFS_STATUS: rdata_nxt = {30'h0, stat_r};
        cpm_pkg::OFS_MASK: rdata_nxt = {30'h0, mask_r};
        default: rresp_nxt = cpm_pkg::RESP_SLVERR;
      endcase
    end
    // RQ13 sticky flags, read clears, a new event wins
    stat_nxt = stat_r;
    if (rd_take && s_axi_araddr == cpm_pkg::OFS_STATUS)
    begin
      stat_nxt = 2'h0;
    end
    stat_nxt = stat_nxt | stat_set;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_r <= cpm_pkg::CONFIG_RST;
      cal_r <= cpm_pkg::CAL_RST;
      limit_r <= cpm_pkg::LIMIT_RST;
      mask_r <= cpm_pkg::MASK_RST;
      stat_r <= 2'h0;
      irq_r <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cpm_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= cpm_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      cal_r <= cal_nxt;
      limit_r <= limit_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement sequencer

  cpm_state_t st_r, st_nxt;
  logic req_nxt, mux_nxt;
  logic [AVG_LOG_MAX:0] cnt_r, cnt_nxt;
  logic [2:0] avg_n_r, avg_n_nxt;
  logic signed [cpm_pkg::ACC_W-1:0] acc_sh_r, acc_sh_nxt;
  logic [cpm_pkg::ACC_W-1:0] acc_rl_r, acc_rl_nxt;
  logic signed [15:0] code_sh;
  logic signed [cpm_pkg::ACC_W-1:0] avg_sh;
  logic [cpm_pkg::ACC_W-1:0] avg_rl;
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_scaled;
  logic [15:0] cur_mag;
  logic [31:0] pwr_prod;
  logic [31:0] pwr_scaled;
  logic [15:0] pwr_val;
  logic over;
  cpm_pkg::cpm_alert_sel_t alert_sel;

  always_comb
  begin
    st_nxt = st_r;
    req_nxt = 1'b0;
    mux_nxt = mux_sel_r;
    cnt_nxt = cnt_r;
    avg_n_nxt = avg_n_r;
    acc_sh_nxt = acc_sh_r;
    acc_rl_nxt = acc_rl_r;
    res_nxt = res_r;
    stat_set = 2'h0;
    over = 1'b0;
    alert_sel = cpm_pkg::cpm_alert_sel_t'(cfg_r[cpm_pkg::CFG_ALERT_HI:cpm_pkg::CFG_ALERT_LO]);
    // RQ2 RQ3 clamp shunt code to the 80 mv span of 2.5 uv steps
    code_sh = $signed(rx_word);
    if (code_sh > cpm_pkg::SHUNT_MAX)
    begin
      code_sh = cpm_pkg::SHUNT_MAX;
    end
    else if (code_sh < cpm_pkg::SHUNT_MIN)
    begin
      code_sh = cpm_pkg::SHUNT_MIN;
    end
    // RQ11 average by power-of-two count
    avg_sh = acc_sh_r >>> avg_n_r;
    avg_rl = acc_rl_r >> avg_n_r;
    // RQ12 current scaling
    cur_prod = $signed({{17{avg_sh[15]}}, avg_sh[15:0]}) * $signed({17'h0, cal_r});
    cur_scaled = cur_prod >>> cpm_pkg::CUR_SHIFT;
    cur_mag = res_r.current[15] ? 16'(-$signed(res_r.current)) : res_r.current;
    // RQ12 power scaling, saturated instead of wrapping
    pwr_prod = {16'h0000, cur_mag} * {16'h0000, res_r.rail};
    pwr_scaled = pwr_prod >> cpm_pkg::PWR_SHIFT;
    pwr_val = (|pwr_scaled[31:16]) ? 16'hffff : pwr_scaled[15:0];
    unique case (st_r)
      S_IDLE:
      begin
        if (cfg_r[cpm_pkg::CFG_RUN])
        begin
          avg_n_nxt = (cfg_r[cpm_pkg::CFG_AVG_HI:cpm_pkg::CFG_AVG_LO] > 3'(AVG_LOG_MAX)) ?
                      3'(AVG_LOG_MAX) : cfg_r[cpm_pkg::CFG_AVG_HI:cpm_pkg::CFG_AVG_LO];
          mux_nxt = cpm_pkg::MUX_SHUNT;
          req_nxt = 1'b1;
          st_nxt = S_SHUNT;
        end
      end
      S_SHUNT:
      begin
        if (rx_valid)
        begin
          acc_sh_nxt = acc_sh_r + cpm_pkg::ACC_W'(code_sh);
          // RQ6 switch to rail input
          mux_nxt = cpm_pkg::MUX_RAIL;
          req_nxt = 1'b1;
          st_nxt = S_RAIL;
        end
      end
      S_RAIL:
      begin
        if (rx_valid)
        begin
          acc_rl_nxt = acc_rl_r + {{(cpm_pkg::ACC_W-CODE_W){1'b0}}, rx_word};
          if (cnt_r == (AVG_LOG_MAX+1)'((1 << avg_n_r) - 1))
          begin
            st_nxt = S_CUR;
          end
          else
          begin
            cnt_nxt = cnt_r + 1'b1;
            // RQ6 back to shunt input
            mux_nxt = cpm_pkg::MUX_SHUNT;
            req_nxt = 1'b1;
            st_nxt = S_SHUNT;
          end
        end
      end
      S_CUR:
      begin
        // RQ5 store current in its own result register
        res_nxt.shunt = avg_sh[15:0];
        res_nxt.rail = avg_rl[15:0];
        res_nxt.current = cur_scaled[15:0];
        st_nxt = S_PWR;
      end
      S_PWR:
      begin
        // RQ7 store power
        res_nxt.power = pwr_val;
        // RQ9 RQ10 limit comparison by selected quantity
        unique case (alert_sel)
          cpm_pkg::ALERT_OFF: over = 1'b0;
          cpm_pkg::ALERT_OVER_CURRENT: over = $signed(res_r.current) > $signed(limit_r);
          cpm_pkg::ALERT_OVER_VOLTAGE: over = res_r.rail > limit_r;
          cpm_pkg::ALERT_OVER_POWER: over = pwr_val > limit_r;
        endcase
        stat_set[cpm_pkg::ST_DONE] = 1'b1;
        // RQ13 raise alert flag
        stat_set[cpm_pkg::ST_ALERT] = over;
        acc_sh_nxt = '0;
        acc_rl_nxt = '0;
        cnt_nxt = '0;
        st_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= S_IDLE;
      conv_req_r <= 1'b0;
      mux_sel_r <= cpm_pkg::MUX_SHUNT;
      cnt_r <= '0;
      avg_n_r <= 3'h0;
      acc_sh_r <= '0;
      acc_rl_r <= '0;
      res_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      conv_req_r <= req_nxt;
      mux_sel_r <= mux_nxt;
      cnt_r <= cnt_nxt;
      avg_n_r <= avg_n_nxt;
      acc_sh_r <= acc_sh_nxt;
      acc_rl_r <= acc_rl_nxt;
      res_r <= res_nxt;
    end
  end

endmodule

// >>> cpm_core_sva.sv
`timescale 1ns/1ns
module cpm_core_sva (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter
  input wire logic conv_req_r,
  input wire logic mux_sel_r
);
  logic [7:0] ra_r;
  logic [7:0] ra_nxt;
  logic mux_r;
  logic mux_nxt;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // reset to rail so the first request must be a shunt one
  always_comb
  begin
    ra_nxt = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_r;
    mux_nxt = conv_req_r ? mux_sel_r : mux_r;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ra_r <= 8'h00;
      mux_r <= cpm_pkg::MUX_RAIL;
    end
    else
    begin
      ra_r <= ra_nxt;
      mux_r <= mux_nxt;
    end
  end
  ////////////////////////////////////////
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle after its address");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp))
    else $error("read data changed before it was taken");
  a_write_answer: assert property (s_w_take |=> s_axi_bvalid)
    else $error("write not answered one cycle after address and data");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data pending");
  a_req_pulse: assert property (conv_req_r |=> !conv_req_r [*2])
    else $error("conversion request longer than one cycle");
  a_mux_alternate: assert property (conv_req_r |-> mux_sel_r != mux_r)
    else $error("input selection did not alternate");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data wider than a 16 bit code");
  a_err_zero: assert property (
    s_axi_rvalid && s_axi_rresp == cpm_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returned data");
  a_shunt_span: assert property (
    s_axi_rvalid && ra_r == cpm_pkg::OFS_SHUNT |-> $signed(s_axi_rdata[15:0])
      <= cpm_pkg::SHUNT_MAX && $signed(s_axi_rdata[15:0]) >= cpm_pkg::SHUNT_MIN)
    else $error("shunt code outside the full scale span");
endmodule
bind cpm_core cpm_core_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .conv_req_r(conv_req_r),
  .mux_sel_r(mux_sel_r)
);

// >>> cpm_pkg.sv
package cpm_pkg;

  // conversion codes and scaling
  localparam int CODE_W = 16;
  localparam int SHUNT_LSB_NV = 2500;
  localparam int FULL_SCALE_UV = 80000;
  localparam int SHUNT_CLAMP = FULL_SCALE_UV * 1000 / SHUNT_LSB_NV;
  localparam logic signed [15:0] SHUNT_MAX = 16'(SHUNT_CLAMP);
  localparam logic signed [15:0] SHUNT_MIN = 16'(-SHUNT_CLAMP);
  localparam int CUR_SHIFT = 11;
  localparam int PWR_SHIFT = 15;
  localparam int AVG_LOG_MAX = 7;
  localparam int ACC_W = CODE_W + AVG_LOG_MAX + 1;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SHUNT = 8'h04;
  localparam logic [7:0] OFS_RAIL = 8'h08;
  localparam logic [7:0] OFS_POWER = 8'h0c;
  localparam logic [7:0] OFS_CURRENT = 8'h10;
  localparam logic [7:0] OFS_CAL = 8'h14;
  localparam logic [7:0] OFS_LIMIT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_MASK = 8'h20;

  // config fields
  localparam int CFG_RUN = 0;
  localparam int CFG_AVG_LO = 1;
  localparam int CFG_AVG_HI = 3;
  localparam int CFG_ALERT_LO = 4;
  localparam int CFG_ALERT_HI = 5;
  localparam int CFG_W = 6;

  // status / mask fields
  localparam int ST_DONE = 0;
  localparam int ST_ALERT = 1;
  localparam int ST_W = 2;

  // reset values
  localparam logic [5:0] CONFIG_RST = 6'h00;
  localparam logic [15:0] CAL_RST = 16'h0000;
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [1:0] MASK_RST = 2'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // converter input selection
  localparam logic MUX_SHUNT = 1'b0;
  localparam logic MUX_RAIL = 1'b1;

  typedef enum logic [1:0] {
    ALERT_OFF = 2'h0,
    ALERT_OVER_CURRENT = 2'h1,
    ALERT_OVER_VOLTAGE = 2'h2,
    ALERT_OVER_POWER = 2'h3
  } cpm_alert_sel_t;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] rail;
    logic [15:0] current;
    logic [15:0] power;
  } cpm_result_t;

endpackage

// >>> cpm_rx.sv
`timescale 1ns/1ns
module cpm_rx #(
  parameter int CODE_W = 16
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // converter serial link, asynchronous
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_frame_n,
  // decoded word
  output logic [CODE_W-1:0] word_r,
  output logic valid_r
);

  logic [2:0] clk_sync_r, clk_sync_nxt;
  logic [1:0] dat_sync_r, dat_sync_nxt;
  logic [2:0] frm_sync_r, frm_sync_nxt;
  logic [CODE_W-1:0] shift_r, shift_nxt;
  logic [$clog2(CODE_W+1)-1:0] cnt_r, cnt_nxt;
  logic [CODE_W-1:0] word_nxt;
  logic valid_nxt;
  logic rise;
  logic frm_end;

  ////////////////////////////////////////////////////////////////////////////

  // stage 0 feeds only stage 1; stage 2 is a delayed copy for edge finding
  always_comb
  begin
    clk_sync_nxt = {clk_sync_r[1:0], link_clk};
    dat_sync_nxt = {dat_sync_r[0], link_data};
    frm_sync_nxt = {frm_sync_r[1:0], link_frame_n};
    rise = clk_sync_r[1] & ~clk_sync_r[2];
    frm_end = frm_sync_r[1] & ~frm_sync_r[2];
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    word_nxt = word_r;
    valid_nxt = 1'b0;
    if (frm_sync_r[2])
    begin
      cnt_nxt = '0;
    end
    else if (rise && cnt_r < ($clog2(CODE_W+1))'(CODE_W))
    begin
      shift_nxt = {shift_r[CODE_W-2:0], dat_sync_r[1]};
      cnt_nxt = cnt_r + 1'b1;
    end
    // a short frame is dropped, not passed on
    if (frm_end && cnt_r == ($clog2(CODE_W+1))'(CODE_W))
    begin
      word_nxt = shift_r;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_sync_r <= 3'h0;
      dat_sync_r <= 2'h0;
      frm_sync_r <= 3'h7;
      shift_r <= '0;
      cnt_r <= '0;
      word_r <= '0;
      valid_r <= 1'b0;
    end
    else
    begin
      clk_sync_r <= clk_sync_nxt;
      dat_sync_r <= dat_sync_nxt;
      frm_sync_r <= frm_sync_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      word_r <= word_nxt;
      valid_r <= valid_nxt;
    end
  end

endmodule

// >>> test_current_power_monitor_core.sv
`timescale 1ns/1ns
module test_current_power_monitor_core;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, short_fr;
  logic awready, wready, bvalid, arready, rvalid, lclk, ldata, lframe_n, conv_req, mux_sel, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] sh_a, sh_b, rail_v, n_frames;
  int n_errors, total_checks;
  cpm_core dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_clk(lclk), .link_data(ldata), .link_frame_n(lframe_n), .conv_req_r(conv_req),
    .mux_sel_r(mux_sel), .irq_r(irq)
  );
  cpm_conv_model conv (
    .aclk(aclk), .conv_req_r(conv_req), .mux_sel_r(mux_sel), .shunt_a(sh_a), .shunt_b(sh_b),
    .rail(rail_v), .short_frame(short_fr), .link_clk(lclk), .link_data(ldata),
    .link_frame_n(lframe_n), .n_frames(n_frames)
  );
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    chk(what, 34'h0, 34'h1);
    tally_and_finish();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    logic got;
    t = 0;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && t < 100)
    begin
      @(posedge aclk);
      t++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      got = bvalid;
    end
    if (!got)
      hang("write timeout");
    chk("write response", 34'(bresp), 34'(er));
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [33:0] exp);
    int t;
    logic got;
    t = 0;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && t < 100)
    begin
      @(posedge aclk);
      t++;
      if (arready)
        arvalid <= 1'b0;
      got = rvalid;
    end
    if (!got)
      hang("read timeout");
    chk(what, {rresp, rdata}, exp);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  function automatic int clip(input logic [15:0] v);
    int s;
    s = int'($signed(v));
    return (s > 32000) ? 32000 : (s < -32000) ? -32000 : s;
  endfunction
  // run one block with run cleared at once, so exactly one result set appears
  task automatic run_case(input logic [2:0] n, input logic [1:0] sel, input logic [15:0] lim,
    input logic [15:0] cal, input logic [1:0] msk, input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] rl, input logic shf);
    int t, c;
    logic [15:0] f0, avg, cur;
    logic [31:0] pw;
    logic al;
    avg = 16'((n == 3'h0) ? clip(a) : (clip(a) + clip(b)) >>> 1);
    cur = 16'((int'($signed(avg)) * int'(cal)) >>> 11);
    c = int'($signed(cur));
    pw = 32'(((c < 0) ? -c : c) * int'(rl)) >> 15;
    pw = (pw > 32'h0000_ffff) ? 32'h0000_ffff : pw;
    al = (sel == 2'h1) ? ($signed(cur) > $signed(lim)) : (sel == 2'h2) ? (rl > lim) :
      (sel == 2'h3) ? (pw > {16'h0000, lim}) : 1'b0;
    sh_a <= a;
    sh_b <= b;
    rail_v <= rl;
    short_fr <= shf;
    axi_wr(cpm_pkg::OFS_CAL, {16'h0000, cal}, cpm_pkg::RESP_OKAY);
    axi_wr(cpm_pkg::OFS_LIMIT, {16'h0000, lim}, cpm_pkg::RESP_OKAY);
    axi_wr(cpm_pkg::OFS_MASK, {30'h0, msk}, cpm_pkg::RESP_OKAY);
    f0 = n_frames;
    axi_wr(cpm_pkg::OFS_CONFIG, {26'h0, sel, n, 1'b1}, cpm_pkg::RESP_OKAY);
    axi_wr(cpm_pkg::OFS_CONFIG, {26'h0, sel, n, 1'b0}, cpm_pkg::RESP_OKAY);
    t = 0;
    while (n_frames != f0 + (16'h0002 << n) && t < 20000)
    begin
      @(posedge aclk);
      t++;
    end
    if (t >= 20000)
      hang("conversion timeout");
    // frame sync plus compute is a few cycles; 20 leaves margin
    repeat (20) @(posedge aclk);
    chk("irq raised", 34'(irq), 34'(|(msk & {al, 1'b1})));
    rchk("shunt", cpm_pkg::OFS_SHUNT, {18'h0, avg});
    rchk("rail", cpm_pkg::OFS_RAIL, {18'h0, rl});
    rchk("current", cpm_pkg::OFS_CURRENT, {18'h0, cur});
    rchk("power", cpm_pkg::OFS_POWER, {2'h0, pw});
    rchk("status", cpm_pkg::OFS_STATUS, {32'h0, al, 1'b1});
    rchk("status cleared", cpm_pkg::OFS_STATUS, 34'h0);
    chk("irq cleared", 34'(irq), 34'h0);
  endtask
  ////////////////////////////////////////
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, short_fr} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {sh_a, sh_b, rail_v} = 48'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 9; i++)
      rchk("reset value", 8'(4 * i), 34'h0);
    rchk("unmapped read", 8'h24, {cpm_pkg::RESP_SLVERR, 32'h0});
    axi_wr(8'h24, 32'h1, cpm_pkg::RESP_SLVERR);
    axi_wr(cpm_pkg::OFS_SHUNT, 32'h1234, cpm_pkg::RESP_OKAY);
    rchk("shunt read only", cpm_pkg::OFS_SHUNT, 34'h0);
    axi_wr(cpm_pkg::OFS_CONFIG, 32'hffff_ffc0, cpm_pkg::RESP_OKAY);
    rchk("config width", cpm_pkg::OFS_CONFIG, 34'h0);
    axi_wr(cpm_pkg::OFS_CAL, 32'h1234_abcd, cpm_pkg::RESP_OKAY);
    rchk("cal", cpm_pkg::OFS_CAL, 34'h0_abcd);
    run_case(3'h0, 2'h1, 16'd1999, 16'd4096, 2'h1, 16'd1000, 16'd1000, 16'd2000, 1'b0);
    run_case(3'h0, 2'h3, 16'd122, 16'd4096, 2'h2, 16'd1000, 16'd1000, 16'd2000, 1'b0);
    run_case(3'h0, 2'h2, 16'd1999, 16'd4096, 2'h2, 16'd1000, 16'd1000, 16'd2000, 1'b0);
    run_case(3'h0, 2'h0, 16'd0, 16'd4096, 2'h3, -16'sd1000, -16'sd1000, 16'd2000, 1'b0);
    run_case(3'h0, 2'h3, 16'd121, 16'd1024, 2'h0, 16'h7fff, 16'h7fff, 16'd2000, 1'b1);
    run_case(3'h1, 2'h1, 16'h7fff, 16'd2048, 2'h3, 16'd1000, 16'd1201, 16'd3000, 1'b0);
    tally_and_finish();
  end
endmodule
